// *** logic/asq_sequencer.v ***
// Acquisition scan sequencer: scan timing, triggering, pretrigger and burst counting
// Operation
// - Aggregate burst rate capped at 100k samples/s, shared by enabled channels.
// - All twelve digital inputs captured together, at the analog sample rate.
// - Output updates from internal buffer up to 100k per second.
// - Synchronised units all start on one shared start, first channel together.
// - Analog input buffer 32000 in burst, 8000 when continuous or shared.
// - Digital in, analog out, digital out buffers each hold 8000 samples.
// - Burst starts by software command, trigger pin level or analog condition.
// - Pretrigger keeps capturing and retains requested points before the trigger.
// - Without averaging, scan channels back to back, repeat at sample period.
// - Channel spacing 10 us at full rate, 1 us steps, at most 20 us.
// - Slower rates add idle time after the last channel of a scan.
// - Averaging modes combine 8, 32 or 256 conversions, rate reduced alike.
// - Low-noise reads 256 conversions, scan period one line period of 50 or 60 Hz per channel.
`timescale 1ns/1ps
`include "asq_defs.vh"
module asq_sequencer #(
  parameter NCH     = 16,
  parameter DEPTH_W = 16
) (
  input  wire                     sys_clk,
  input  wire                     rst,
  input  wire                     enable,
  input  wire                     contMode,
  input  wire                     otherIoActive,
  input  wire [NCH-1:0]           chanEnable,
  input  wire [2:0]               resMode,
  input  wire                     line60Hz,
  input  wire [1:0]               trigSource,
  input  wire                     trigPinLevel,
  input  wire                     trigPin,
  input  wire [`ASQ_CH_W-1:0]     trigChan,
  input  wire                     trigAnalogAbove,
  input  wire [12:0]              trigThreshold,
  input  wire                     softStart,
  input  wire                     syncStartIn,
  input  wire                     syncMode,
  input  wire [`ASQ_US_W-1:0]     scanPeriodUs,
  input  wire [DEPTH_W-1:0]       burstLength,
  input  wire [DEPTH_W-1:0]       preTrigCount,
  input  wire [`ASQ_DIN_W-1:0]    digIn,
  input  wire [12:0]              adcData,
  input  wire                     adcReady,
  input  wire                     outSlotFree,
  output reg                      syncStartOut,
  output reg                      convStart,
  output reg  [`ASQ_CH_W-1:0]     convChan,
  output wire [31:0]              smpData,
  output wire                     smpValid,
  input  wire                     smpReady,
  output reg                      outUpdate,
  output reg                      armed,
  output reg                      triggered,
  output reg                      burstDone,
  output reg                      overflow,
  output reg  [DEPTH_W-1:0]       capacity
);
  // ===========================================================
  // State encoding and helpers
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SCAN = 2'h2;
  localparam ST_GAP  = 2'h3;

  function [`ASQ_US_W-1:0] popCount;
    input [NCH-1:0] v;
    integer i;
    begin
      popCount = {`ASQ_US_W{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        popCount = popCount + {{(`ASQ_US_W-1){1'b0}}, v[i]};
      end
    end
  endfunction

  function [`ASQ_CH_W-1:0] nextChan;
    input [NCH-1:0]       v;
    input [`ASQ_CH_W-1:0] from;
    integer k;
    reg found;
    begin
      found = 1'b0;
      nextChan = from;
      for (k = NCH - 1; k >= 0; k = k - 1) begin
        if (v[k] && (k > from)) begin
          nextChan = k[`ASQ_CH_W-1:0];
          found = 1'b1;
        end
      end
      if (!found) begin
        nextChan = from;
      end
    end
  endfunction

  // ===========================================================
  // One-microsecond time base
  reg  [`ASQ_TICK_W-1:0] tickCnt_q;
  wire                   usTick = (tickCnt_q == `ASQ_US_CYCLES - 1);
  wire                   tickSync;

  // Restarting the tick at a scan start keeps channel spacing whole microseconds
  always @(posedge sys_clk) begin
    if (rst || !enable || tickSync) begin
      tickCnt_q <= {`ASQ_TICK_W{1'b0}};
    end else begin
      tickCnt_q <= usTick ? {`ASQ_TICK_W{1'b0}} : tickCnt_q + 1'b1;
    end
  end

  // ===========================================================
  // Timing derived from host configuration
  wire [`ASQ_US_W-1:0] nCh     = popCount(chanEnable);
  wire [`ASQ_US_W-1:0] avgMul  = (resMode == `ASQ_RES_AVG8)   ? 24'd8 :
                                 (resMode == `ASQ_RES_AVG32)  ? 24'd32 :
                                 (resMode == `ASQ_RES_AVG256) ? 24'd256 : 24'd1;
  // Each enabled channel costs at least 10 us per conversion, so 100k/s is shared
  wire [`ASQ_US_W-1:0] minPer  = nCh * `ASQ_MIN_PERIOD_US * avgMul;
  wire [`ASQ_US_W-1:0] linePer = line60Hz ? `ASQ_LINE60_US : `ASQ_LINE50_US;
  wire [`ASQ_US_W-1:0] perReq  = (resMode == `ASQ_RES_LOWNOISE) ? linePer * nCh :
                                 ((scanPeriodUs < minPer) ? minPer : scanPeriodUs);
  // Spacing per conversion: period / (channels x average count), clamped to 10..20 us
  wire [`ASQ_US_W-1:0] perConv = (nCh == 0) ? perReq : perReq / (nCh * avgMul);
  wire [`ASQ_TICK_W-1:0] spacing =
    (resMode == `ASQ_RES_LOWNOISE)  ? `ASQ_SPACE_MAX_US :
    (perConv >= 24'd20)             ? `ASQ_SPACE_MAX_US :
    (perConv <= 24'd10)             ? `ASQ_SPACE_MIN_US : perConv[`ASQ_TICK_W-1:0];
  // Line-cycle averaging is modelled as a fixed count of 256 conversions per reading
  wire [8:0] convsPerRead = (resMode == `ASQ_RES_LOWNOISE) ? 9'd256 : avgMul[8:0];

  // ===========================================================
  // Trigger detection
  reg        trigPinLast_q;
  wire       pinEvent  = (trigPin == trigPinLevel) && (trigPinLast_q != trigPinLevel);
  wire       anaEvent  = adcReady && (convChan == trigChan) &&
                         (trigAnalogAbove ? (adcData > trigThreshold) : (adcData < trigThreshold));
  wire       trigEvent = (trigSource == `ASQ_TRG_SOFT)   ? softStart :
                         (trigSource == `ASQ_TRG_PIN)    ? pinEvent :
                         (trigSource == `ASQ_TRG_ANALOG) ? anaEvent : 1'b0;

  // ===========================================================
  // Scan state machine
  reg [1:0]            state_q;
  reg [`ASQ_US_W-1:0]  perCnt_q;
  reg [`ASQ_TICK_W-1:0] spcCnt_q;
  reg [8:0]            avgCnt_q;
  reg [20:0]           acc_q;
  reg [DEPTH_W-1:0]    stored_q;
  reg [DEPTH_W-1:0]    postLeft_q;
  reg [`ASQ_DIN_W-1:0] digSnap_q;
  reg [31:0]           word_q;
  reg                  wordValid_q;
  wire                 fifoReady;
  wire [`ASQ_CH_W-1:0] firstChan = nextChan(chanEnable, {`ASQ_CH_W{1'b0}});
  wire [`ASQ_CH_W-1:0] firstIdx  = chanEnable[0] ? {`ASQ_CH_W{1'b0}} : firstChan;
  wire [`ASQ_CH_W-1:0] nxt       = nextChan(chanEnable, convChan);
  wire                 lastChan  = (nxt == convChan);
  wire                 startNow  = syncMode ? syncStartIn : 1'b1;
  assign tickSync = (state_q == ST_WAIT) && startNow;
  wire [20:0]          accNext   = acc_q + {8'h00, adcData};
  wire [12:0]          avgOut    = (convsPerRead == 9'd8)  ? accNext[15:3] :
                                   (convsPerRead == 9'd32) ? accNext[17:5] :
                                   (convsPerRead == 9'd256) ? accNext[20:8] : adcData;

  always @(posedge sys_clk) begin
    if (rst || !enable) begin
      state_q       <= ST_IDLE;
      perCnt_q      <= {`ASQ_US_W{1'b0}};
      spcCnt_q      <= {`ASQ_TICK_W{1'b0}};
      avgCnt_q      <= 9'h000;
      acc_q         <= 21'h000000;
      stored_q      <= {DEPTH_W{1'b0}};
      postLeft_q    <= {DEPTH_W{1'b0}};
      digSnap_q     <= {`ASQ_DIN_W{1'b0}};
      word_q        <= 32'h00000000;
      wordValid_q   <= 1'b0;
      convStart     <= 1'b0;
      convChan      <= {`ASQ_CH_W{1'b0}};
      syncStartOut  <= 1'b0;
      armed         <= 1'b0;
      triggered     <= 1'b0;
      burstDone     <= 1'b0;
      overflow      <= 1'b0;
      trigPinLast_q <= 1'b0;
    end else begin
      trigPinLast_q <= trigPin;
      convStart     <= 1'b0;
      syncStartOut  <= 1'b0;
      if (wordValid_q && fifoReady) begin
        wordValid_q <= 1'b0;
      end
      if (trigEvent && armed && !triggered) begin
        triggered  <= 1'b1;
        postLeft_q <= (burstLength > preTrigCount) ? burstLength - preTrigCount :
                      {{(DEPTH_W-1){1'b0}}, 1'b1};
      end
      case (state_q)
        ST_IDLE: begin
          if (!burstDone && chanEnable != {NCH{1'b0}}) begin
            armed        <= 1'b1;
            syncStartOut <= 1'b1;
            state_q      <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (startNow) begin
            convChan <= firstIdx;
            perCnt_q <= perReq;
            spcCnt_q <= spacing;
            digSnap_q <= digIn;
            convStart <= 1'b1;
            state_q   <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (usTick) begin
            perCnt_q <= (perCnt_q != 0) ? perCnt_q - 1'b1 : perCnt_q;
            spcCnt_q <= (spcCnt_q != 0) ? spcCnt_q - 1'b1 : spcCnt_q;
          end
          if (adcReady) begin
            if (avgCnt_q + 1'b1 < convsPerRead) begin
              avgCnt_q <= avgCnt_q + 1'b1;
              acc_q    <= accNext;
            end else begin
              avgCnt_q <= 9'h000;
              acc_q    <= 21'h000000;
              // Pretrigger: keep writing samples before trigger; the host ring keeps
              // the last preTrigCount of them
              if (!wordValid_q || fifoReady) begin
                word_q      <= {3'h0, convChan, digSnap_q, avgOut};
                wordValid_q <= 1'b1;
                stored_q    <= stored_q + 1'b1;
                if (triggered) begin
                  postLeft_q <= postLeft_q - 1'b1;
                end
              end else begin
                overflow <= 1'b1;
              end
            end
          end
          if (stored_q >= capacity || (triggered && postLeft_q == 0)) begin
            burstDone <= 1'b1;
            armed     <= 1'b0;
            state_q   <= ST_IDLE;
          end else if (usTick && spcCnt_q == 1) begin
            if (avgCnt_q != 0 || !lastChan) begin
              convChan  <= (avgCnt_q != 0) ? convChan : nxt;
              spcCnt_q  <= spacing;
              convStart <= 1'b1;
            end else if (perCnt_q <= 1 && startNow) begin
              convChan  <= firstIdx;
              perCnt_q  <= perReq;
              spcCnt_q  <= spacing;
              digSnap_q <= digIn;
              convStart <= 1'b1;
            end else begin
              state_q <= (perCnt_q <= 1) ? ST_WAIT : ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (usTick && perCnt_q != 0) begin
            perCnt_q <= perCnt_q - 1'b1;
          end
          if (perCnt_q <= 1 && usTick) begin
            if (startNow) begin
              convChan  <= firstIdx;
              perCnt_q  <= perReq;
              spcCnt_q  <= spacing;
              digSnap_q <= digIn;
              convStart <= 1'b1;
              state_q   <= ST_SCAN;
            end else begin
              state_q <= ST_WAIT;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ===========================================================
  // Output update pacing: one update per 10 us at most; counted in cycles so a
  // tick restart at scan start cannot shorten the gap
  reg [7:0] outCnt_q;
  always @(posedge sys_clk) begin
    if (rst || !enable) begin
      outCnt_q  <= 8'h00;
      outUpdate <= 1'b0;
    end else begin
      outUpdate <= 1'b0;
      if (outCnt_q != 8'h00) begin
        outCnt_q <= outCnt_q - 8'h01;
      end
      if (outCnt_q == 8'h00 && outSlotFree) begin
        outUpdate <= 1'b1;
        outCnt_q  <= `ASQ_OUT_GAP_CYC;
      end
    end
  end

  // Capacity follows the activity mode even while the sequencer is disabled
  always @(posedge sys_clk) begin
    if (rst) begin
      capacity <= `ASQ_BURST_DEPTH;
    end else begin
      capacity <= (contMode || otherIoActive) ? `ASQ_SHARED_DEPTH : `ASQ_BURST_DEPTH;
    end
  end

  // ===========================================================
  // Sample FIFO toward the host port; a stall here costs samples, not timing
  asq_fifo #(
    .WIDTH (32),
    .DEPTH (4),
    .AW    (2)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inData   (word_q),
    .inValid  (wordValid_q),
    .inReady  (fifoReady),
    .outData  (smpData),
    .outValid (smpValid),
    .outReady (smpReady)
  );
  // Storage depths for digital and output buffers live in the host RAM controller
  // and are fixed at ASQ_SHARED_DEPTH
endmodule

// *** common/asq_defs.vh ***
// Constants shared by the acquisition scan sequencer files
`ifndef ASQ_DEFS_VH
`define ASQ_DEFS_VH

`define ASQ_CLK_MHZ        20
`define ASQ_US_CYCLES      20
`define ASQ_TICK_W         5
`define ASQ_MAX_RATE_SPS   100000
`define ASQ_MIN_PERIOD_US  10
`define ASQ_SPACE_MIN_US   5'h0a
`define ASQ_SPACE_MAX_US   5'h14
// One less than the clock cycles in 10 us, the shortest output update gap
`define ASQ_OUT_GAP_CYC    8'hc7
`define ASQ_US_W           24
`define ASQ_DIN_W          12
`define ASQ_CH_W           4
`define ASQ_BURST_DEPTH    16'h7d00
`define ASQ_SHARED_DEPTH   16'h1f40
`define ASQ_LINE50_US      24'h004e20
`define ASQ_LINE60_US      24'h00411b
`define ASQ_RES_13         3'h0
`define ASQ_RES_AVG8       3'h1
`define ASQ_RES_AVG32      3'h2
`define ASQ_RES_AVG256     3'h3
`define ASQ_RES_LOWNOISE   3'h4
`define ASQ_TRG_SOFT       2'h0
`define ASQ_TRG_PIN        2'h1
`define ASQ_TRG_ANALOG     2'h2

`endif

// *** logic/asq_fifo.v ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module asq_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      count_q;
  wire            doWr;
  wire            doRd;

  assign inReady  = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_q];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always @(posedge sys_clk) begin
    if (doWr) begin
      mem[wrPtr_q] <= inData;
    end
    if (rst) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      end
      if (doWr && !doRd) begin
        count_q <= count_q + 1'b1;
      end else if (doRd && !doWr) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// *** verif/asq_seq_properties.sv ***
// Port-level assertions for the acquisition scan sequencer
`timescale 1ns/1ps
`include "asq_defs.vh"
module asq_seq_properties #(
  parameter NCH     = 16,
  parameter DEPTH_W = 16
) (
  input wire                 sys_clk,
  input wire                 rst,
  input wire                 enable,
  input wire                 contMode,
  input wire                 otherIoActive,
  input wire [NCH-1:0]       chanEnable,
  input wire [1:0]           trigSource,
  input wire                 trigPinLevel,
  input wire                 trigPin,
  input wire                 syncMode,
  input wire [DEPTH_W-1:0]   preTrigCount,
  input wire                 convStart,
  input wire [`ASQ_CH_W-1:0] convChan,
  input wire                 outUpdate,
  input wire                 syncStartOut,
  input wire                 armed,
  input wire                 triggered,
  input wire                 burstDone,
  input wire [DEPTH_W-1:0]   capacity
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Gap counters: 10 us is 200 cycles, so 8 bits saturating is enough
  reg [7:0] convGap_q;
  reg [7:0] outGap_q;
  always @(posedge sys_clk) begin
    if (rst || !enable) begin
      convGap_q <= 8'hff;
      outGap_q  <= 8'hff;
    end else begin
      convGap_q <= convStart ? 8'h00 : convGap_q + {7'h00, convGap_q != 8'hff};
      outGap_q  <= outUpdate ? 8'h00 : outGap_q + {7'h00, outGap_q != 8'hff};
    end
  end
  // ==========================================
  // Assertions
  a_cap_burst: assert property (!$past(rst) && !$past(contMode || otherIoActive)
    && !contMode && !otherIoActive |-> capacity == 16'h7d00) else $error("capacity not 32000");
  a_cap_shared: assert property (!$past(rst) && $past(contMode || otherIoActive)
    && (contMode || otherIoActive) |-> capacity == 16'h1f40) else $error("capacity not 8000");
  a_conv_gap: assert property (convStart |-> convGap_q >= 8'hc7)
    else $error("conversions closer than 10 us");
  a_out_gap: assert property (outUpdate |-> outGap_q >= 8'hc7)
    else $error("output updates closer than 10 us");
  a_conv_enabled: assert property (convStart |-> chanEnable[convChan])
    else $error("conversion on a disabled channel");
  a_pin_start: assert property (armed && !triggered && !syncMode && preTrigCount == 0
    && trigSource == `ASQ_TRG_PIN && trigPin == trigPinLevel |-> ##[1:4] triggered)
    else $error("pin level did not trigger");
  a_done_holds: assert property (burstDone && enable |=> burstDone)
    else $error("burst done dropped while enabled");
  a_sync_pulse: assert property ($rose(armed) |-> syncStartOut ##1 !syncStartOut)
    else $error("shared start pulse missing");
endmodule

bind asq_sequencer asq_seq_properties #(.NCH(NCH), .DEPTH_W(DEPTH_W)) chk (.*);

// *** verif/asq_host_model.sv ***
// Converter front end and host sample sink facing the sequencer
`timescale 1ns/1ps
module asq_host_model (
  input  wire         sys_clk,
  input  wire         rst,
  input  wire         slow,
  input  wire         stall,
  input  wire         convStart,
  input  wire [3:0]   convChan,
  output logic        adcReady,
  output logic [12:0] adcData,
  output logic        smpReady
);
  logic [7:0] wait_q;
  logic [3:0] chan_q;
  // Result data is not held between results, so adcData toggles every cycle; adcReady is a one-cycle pulse
  always @(posedge sys_clk) begin
    if (rst) begin
      wait_q   <= 8'h00;
      chan_q   <= 4'h0;
      adcReady <= 1'b0;
      adcData  <= 13'h0000;
      smpReady <= 1'b0;
    end else begin
      if (convStart) begin
        wait_q <= slow ? 8'h28 : 8'h04;
        chan_q <= convChan;
      end else if (wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
      end
      adcReady <= (wait_q == 8'h01);
      adcData  <= (wait_q == 8'h01) ? {9'h0a5, chan_q} : ~adcData;
      smpReady <= !stall;
    end
  end
endmodule

// *** verif/asq_sequencer_bench.sv ***
// Self-checking bench for the acquisition scan sequencer
`timescale 1ns/1ps
`include "asq_defs.vh"
module asq_sequencer_bench;
  logic        sys_clk, rst, enable, contMode, otherIoActive, line60Hz, slow, stall;
  logic        trigPinLevel, trigPin, trigAnalogAbove, softStart, syncStartIn, syncMode;
  logic        adcReady, outSlotFree, smpReady, smpValid, outUpdate, syncStartOut, convStart;
  logic        armed, triggered, burstDone, overflow;
  logic [15:0] chanEnable, burstLength, preTrigCount, capacity;
  logic [2:0]  resMode;
  logic [1:0]  trigSource;
  logic [3:0]  trigChan, convChan;
  logic [12:0] trigThreshold, adcData;
  logic [23:0] scanPeriodUs;
  logic [11:0] digIn;
  logic [31:0] smpData, firstSmp;
  int          miscompares, tests_run, cyc, nConv, nSmp, nOut, n0;
  int          convT[$];
  logic [3:0]  convC[$];
  int          tP[4] = '{30, 20, 100, 5};
  int          tS[4] = '{15, 10, 20, 10};
  int          tR[4] = '{30, 20, 100, 20};
  wire  [3:0]  flags = {overflow, burstDone, triggered, armed};

  asq_sequencer uut (.*);
  asq_host_model partner (.*);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (convStart === 1'b1) begin
      convT.push_back(cyc);
      convC.push_back(convChan);
      nConv++;
    end
    if (smpValid === 1'b1 && smpReady === 1'b1) begin
      if (nSmp == 0)
        firstSmp = smpData;
      nSmp++;
    end
    if (outUpdate === 1'b1)
      nOut++;
  end

  // ==========================================
  // Tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Below 4 waits on a status flag, from 4 up on a conversion count of b-4
  task waitFor(input int b, input int lim);
    int n;
    n = 0;
    while (!((b < 4) ? flags[b] === 1'b1 : nConv >= b - 4) && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == lim) begin
      miscompares++;
      summarize();
    end
  endtask

  task run(input logic [15:0] mask, input logic [23:0] per);
    @(posedge sys_clk);
    {chanEnable, scanPeriodUs, enable} <= {mask, per, 1'b1};
    waitFor(0, 100);
    softStart <= 1'b1;
    @(posedge sys_clk);
    softStart <= 1'b0;
  endtask

  task stop;
    @(posedge sys_clk);
    enable <= 1'b0;
    repeat (300) @(posedge sys_clk);
    convT.delete();
    convC.delete();
    {nConv, nSmp, nOut} = {32'h0, 32'h0, 32'h0};
  endtask

  // ==========================================
  // Scenarios
  initial begin
    {enable, contMode, otherIoActive, line60Hz, trigPinLevel, trigPin, slow} = 7'h00;
    {trigAnalogAbove, softStart, syncStartIn, syncMode, stall, outSlotFree} = 6'h01;
    {resMode, trigSource, trigChan, trigThreshold} = {`ASQ_RES_13, `ASQ_TRG_SOFT, 17'h00100};
    {chanEnable, burstLength, preTrigCount} = {16'h0001, 16'hffff, 16'h0000};
    {scanPeriodUs, digIn} = {24'h00000a, 12'ha5c};
    {miscompares, tests_run, cyc, nConv, nSmp, nOut} = 192'h0;
    rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check(capacity, 16'h7d00);
    check({syncStartOut, convStart, outUpdate, flags}, 7'h00);
    for (int i = 1; i < 5; i++) begin
      @(posedge sys_clk);
      {contMode, otherIoActive} <= 2'(i);
      repeat (3) @(negedge sys_clk);
      check(capacity, (i == 4) ? 16'h7d00 : 16'h1f40);
    end
    // Spacing, idle time and the aggregate rate cap, fast and slow converter
    for (int i = 0; i < 4; i++) begin
      slow <= (i > 1);
      run(16'h0005, 24'(tP[i]));
      waitFor(7, 3000);
      check(convC[0], 4'h0);
      check(convC[1], 4'h2);
      check(convT[1] - convT[0], tS[i] * 20);
      check(convT[2] - convT[0], tR[i] * 20);
      check(firstSmp, {3'h0, 4'h0, 12'ha5c, 9'h0a5, 4'h0});
      stop();
    end
    trigSource <= `ASQ_TRG_PIN;
    for (int l = 0; l < 2; l++) begin
      {trigPinLevel, trigPin} <= {l[0], !l[0]};
      run(16'h0001, 24'h00000a);
      repeat (50) @(negedge sys_clk);
      check(triggered, 1'b0);
      @(posedge sys_clk);
      trigPin <= l[0];
      waitFor(1, 10);
      stop();
    end
    {trigSource, trigAnalogAbove} <= {`ASQ_TRG_ANALOG, 1'b1};
    run(16'h0001, 24'h00000a);
    waitFor(1, 4000);
    @(negedge sys_clk);
    n0 = nOut;
    repeat (2000) @(negedge sys_clk);
    check(nOut - n0 >= 9 && nOut - n0 <= 10, 1'b1);
    stop();
    // Pretrigger points are not recounted after the trigger
    trigSource <= `ASQ_TRG_SOFT;
    for (int p = 0; p < 2; p++) begin
      {burstLength, preTrigCount} <= {16'h0004, 16'(p)};
      run(16'h0001, 24'h00000a);
      waitFor(1, 100);
      @(negedge sys_clk);
      n0 = nSmp;
      waitFor(2, 5000);
      repeat (400) @(negedge sys_clk);
      check(nSmp - n0, 4 - p);
      check(burstDone, 1'b1);
      stop();
    end
    // Host stalls: four words fill the FIFO, a fifth waits in word_q, the next one is refused
    {burstLength, preTrigCount, stall} <= {16'h0100, 16'h0000, 1'b1};
    run(16'h0001, 24'h00000a);
    waitFor(3, 3000);
    @(negedge sys_clk);
    check({smpValid, nSmp[3:0]}, 5'h10);
    @(posedge sys_clk);
    stall <= 1'b0;
    repeat (8) @(negedge sys_clk);
    check({smpValid, nSmp[3:0]}, 5'h05);
    stop();
    // Averaging: eight conversions make one reading, the scan period grows alike
    resMode <= `ASQ_RES_AVG8;
    run(16'h0001, 24'h00000a);
    waitFor(13, 3000);
    check(convT[8] - convT[0], 1600);
    check(firstSmp, {3'h0, 4'h0, 12'ha5c, 13'h0a50});
    stop();
    resMode <= `ASQ_RES_13;
    syncMode <= 1'b1;
    run(16'h0003, 24'h000014);
    repeat (500) @(negedge sys_clk);
    check(nConv, 0);
    @(posedge sys_clk);
    syncStartIn <= 1'b1;
    @(posedge sys_clk);
    syncStartIn <= 1'b0;
    waitFor(5, 50);
    check(convC[0], 4'h0);
    summarize();
  end
endmodule
